// File: logic/spms_pin_mode.sv
`timescale 1ns/10ps
// Contract
// R1: Four-bit mode field sets pins and timing
// R2: Modes 0/1: pin one low on emitters 4-6
// R3: Mux pin driven only if slots A/B/C used
// R4: Mode 0: pin two off, internal oscillator
// R5: Mode 1: pin two external clock input
// R6: Modes 2/3: pin one is trigger input
// R7: Mode 2: trigger starts, internal exposure timing
// R8: Modes 2/4: pin two is mux control
// R9: Mode 3: exposure from pin-two clock
// R10: Mode 4: pin one drives start-of-sample
// R11: Mode 4: all timing internal
// R12: Trigger synchronised, rising edge starts sample
module spms_pin_mode #(
    parameter int OSC_DIV_P = spms_pkg::OSC_DIV
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic [spms_pkg::MODE_W-1:0] pin_function_select,
    input wire logic slot_abc_enabled,
    input wire logic exposure_active,
    input wire logic [spms_pkg::SLOT_W-1:0] sequence_slot_select,
    input wire logic sample_start_int,
    input wire logic first_sync_pin_in,
    input wire logic second_sync_pin_in,
    output logic first_sync_pin_out,
    output logic first_sync_pin_oe,
    output logic second_sync_pin_out,
    output logic second_sync_pin_oe,
    output logic sample_tick,
    output logic exposure_tick,
    output logic sample_start,
    output logic second_sync_pin_disabled
);
    logic [1:0] pins_sync;
    logic trig_prev_reg, trig_prev_next;
    logic ext_prev_reg, ext_prev_next;
    logic [spms_pkg::OSC_DIV_W-1:0] div_reg, div_next;
    logic osc_reg, osc_next;
    logic p1_out_reg, p1_out_next, p1_oe_reg, p1_oe_next;
    logic p2_out_reg, p2_out_next, p2_oe_reg, p2_oe_next;
    logic stick_reg, stick_next, etick_reg, etick_next;
    logic start_reg, start_next, dis_reg, dis_next;
    spms_pkg::spms_tsrc_e samp_src, expo_src;
    logic trig_rise, ext_rise, osc_rise, mux_level, mux_mode1, mux_mode2;
    logic ctrl_out, dis_mode;

    // Both pins pass two flops before anything looks at them
    spms_sync2 #(.W(2)) u_sync (
        .core_clk(core_clk),
        .rst(rst),
        .clk_en(clk_en),
        .d({second_sync_pin_in, first_sync_pin_in}),
        .q(pins_sync)
    );

    always_comb begin
        samp_src = spms_pkg::SPMS_TS_INT;
        expo_src = spms_pkg::SPMS_TS_INT;
        mux_mode1 = 1'b0;
        mux_mode2 = 1'b0;
        ctrl_out = 1'b0;
        dis_mode = 1'b0;
        case (pin_function_select) // R1
            spms_pkg::MODE_STANDALONE: begin
                mux_mode1 = 1'b1; // R2
                dis_mode = 1'b1; // R4
            end
            spms_pkg::MODE_EXT_CLK: begin
                mux_mode1 = 1'b1; // R2
                samp_src = spms_pkg::SPMS_TS_EXT; // R5
                expo_src = spms_pkg::SPMS_TS_EXT;
            end
            spms_pkg::MODE_TRIG_INT: begin
                samp_src = spms_pkg::SPMS_TS_NONE; // R6 R7
                mux_mode2 = 1'b1; // R8
            end
            spms_pkg::MODE_TRIG_EXT_CLK: begin
                samp_src = spms_pkg::SPMS_TS_NONE; // R6
                expo_src = spms_pkg::SPMS_TS_EXT; // R9
            end
            spms_pkg::MODE_CTRL_OUT: begin
                ctrl_out = 1'b1; // R10 R11
                mux_mode2 = 1'b1; // R8
            end
            default: begin
                dis_mode = 1'b1;
            end
        endcase
    end

    always_comb begin
        trig_prev_next = clk_en ? pins_sync[0] : trig_prev_reg;
        ext_prev_next = clk_en ? pins_sync[1] : ext_prev_reg;
        trig_rise = pins_sync[0] & ~trig_prev_reg; // R12
        ext_rise = pins_sync[1] & ~ext_prev_reg;
        div_next = div_reg;
        osc_next = osc_reg;
        osc_rise = 1'b0;
        if (div_reg == spms_pkg::OSC_DIV_W'(OSC_DIV_P - 1)) begin
            div_next = '0;
            osc_next = ~osc_reg;
            osc_rise = ~osc_reg;
        end else begin
            div_next = div_reg + 1'b1;
        end
        if (!clk_en) begin
            div_next = div_reg;
            osc_next = osc_reg;
        end
        // Low on emitters four to six, high on other exposures
        mux_level = !(sequence_slot_select == spms_pkg::SLOT_A ||
                      sequence_slot_select == spms_pkg::SLOT_B ||
                      sequence_slot_select == spms_pkg::SLOT_C) || !exposure_active;
    end

    always_comb begin
        p1_out_next = p1_out_reg;
        p1_oe_next = p1_oe_reg;
        p2_out_next = p2_out_reg;
        p2_oe_next = p2_oe_reg;
        // Ticks and starts hold as well, so a frozen block replays nothing on wake
        stick_next = stick_reg;
        etick_next = etick_reg;
        start_next = start_reg;
        dis_next = dis_reg;
        if (clk_en) begin
            dis_next = dis_mode; // R4
            p1_out_next = mux_mode1 ? mux_level : 1'b0; // R2
            p1_oe_next = mux_mode1 & slot_abc_enabled; // R3
            p2_out_next = mux_mode2 ? mux_level : 1'b0; // R8
            p2_oe_next = mux_mode2 & slot_abc_enabled; // R3 R8
            if (ctrl_out) begin
                // Pulse stands one core cycle per internal sample start
                p1_out_next = sample_start_int; // R10
                p1_oe_next = 1'b1; // R10
            end
            case (samp_src)
                spms_pkg::SPMS_TS_INT: stick_next = osc_rise; // R4 R11
                spms_pkg::SPMS_TS_EXT: stick_next = ext_rise; // R5
                default: stick_next = 1'b0;
            endcase
            case (expo_src)
                spms_pkg::SPMS_TS_INT: etick_next = osc_rise; // R7
                spms_pkg::SPMS_TS_EXT: etick_next = ext_rise; // R9
                default: etick_next = 1'b0;
            endcase
            if (samp_src == spms_pkg::SPMS_TS_NONE) begin
                start_next = trig_rise; // R6 R12
            end else begin
                start_next = sample_start_int;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            // Match the synchroniser's idle-high reset level
            trig_prev_reg <= 1'b1;
            ext_prev_reg <= 1'b1;
            div_reg <= '0;
            osc_reg <= 1'b0;
            p1_out_reg <= 1'b0;
            p1_oe_reg <= 1'b0;
            p2_out_reg <= 1'b0;
            p2_oe_reg <= 1'b0;
            stick_reg <= 1'b0;
            etick_reg <= 1'b0;
            start_reg <= 1'b0;
            dis_reg <= 1'b1;
        end else begin
            trig_prev_reg <= trig_prev_next;
            ext_prev_reg <= ext_prev_next;
            div_reg <= div_next;
            osc_reg <= osc_next;
            p1_out_reg <= p1_out_next;
            p1_oe_reg <= p1_oe_next;
            p2_out_reg <= p2_out_next;
            p2_oe_reg <= p2_oe_next;
            stick_reg <= stick_next;
            etick_reg <= etick_next;
            start_reg <= start_next;
            dis_reg <= dis_next;
        end
    end

    assign first_sync_pin_out = p1_out_reg;
    assign first_sync_pin_oe = p1_oe_reg;
    assign second_sync_pin_out = p2_out_reg;
    assign second_sync_pin_oe = p2_oe_reg;
    assign sample_tick = stick_reg;
    assign exposure_tick = etick_reg;
    assign sample_start = start_reg;
    assign second_sync_pin_disabled = dis_reg;

    property p_mux_tristate;
        @(posedge core_clk) disable iff (rst)
        (clk_en && !slot_abc_enabled && !ctrl_out) |=> (!first_sync_pin_oe && !second_sync_pin_oe);
    endproperty
    a_mux_tristate: assert property (p_mux_tristate) else $error("mux pin driven without slots"); // R3

    property p_mode0_pin1;
        @(posedge core_clk) disable iff (rst)
        (clk_en && pin_function_select == spms_pkg::MODE_STANDALONE && slot_abc_enabled)
            |=> (first_sync_pin_oe && first_sync_pin_out ==
                 $past(!exposure_active || sequence_slot_select < spms_pkg::SLOT_A ||
                       sequence_slot_select > spms_pkg::SLOT_C));
    endproperty
    a_mode0_pin1: assert property (p_mode0_pin1) else $error("pin one mux level wrong"); // R2

    property p_mode0_dis;
        @(posedge core_clk) disable iff (rst)
        (clk_en && pin_function_select == spms_pkg::MODE_STANDALONE)
            |=> (second_sync_pin_disabled && !second_sync_pin_oe);
    endproperty
    a_mode0_dis: assert property (p_mode0_dis) else $error("pin two not disabled"); // R4

    property p_mode1_ext;
        @(posedge core_clk) disable iff (rst)
        (clk_en && pin_function_select == spms_pkg::MODE_EXT_CLK && ext_rise)
            |=> (sample_tick && exposure_tick);
    endproperty
    a_mode1_ext: assert property (p_mode1_ext) else $error("ext clock edge lost"); // R5

    property p_trig_start;
        @(posedge core_clk) disable iff (rst)
        (clk_en && pin_function_select == spms_pkg::MODE_TRIG_INT) |=> (sample_start == $past(trig_rise));
    endproperty
    a_trig_start: assert property (p_trig_start) else $error("trigger start mismatch"); // R6

    property p_mode2_int;
        @(posedge core_clk) disable iff (rst)
        (clk_en && pin_function_select == spms_pkg::MODE_TRIG_INT)
            |=> (!sample_tick && exposure_tick == $past(osc_rise));
    endproperty
    a_mode2_int: assert property (p_mode2_int) else $error("mode two timing wrong"); // R7

    property p_mode2_pin2;
        @(posedge core_clk) disable iff (rst)
        (clk_en && pin_function_select == spms_pkg::MODE_TRIG_INT && slot_abc_enabled)
            |=> (second_sync_pin_oe && !first_sync_pin_oe);
    endproperty
    a_mode2_pin2: assert property (p_mode2_pin2) else $error("pin two not mux"); // R8

    property p_mode3_exp;
        @(posedge core_clk) disable iff (rst)
        (clk_en && pin_function_select == spms_pkg::MODE_TRIG_EXT_CLK)
            |=> (exposure_tick == $past(ext_rise));
    endproperty
    a_mode3_exp: assert property (p_mode3_exp) else $error("mode three exposure wrong"); // R9

    property p_mode4_out;
        @(posedge core_clk) disable iff (rst)
        (clk_en && pin_function_select == spms_pkg::MODE_CTRL_OUT)
            |=> (first_sync_pin_oe && first_sync_pin_out == $past(sample_start_int));
    endproperty
    a_mode4_out: assert property (p_mode4_out) else $error("controller output wrong"); // R10

    property p_mode4_int;
        @(posedge core_clk) disable iff (rst)
        (clk_en && pin_function_select == spms_pkg::MODE_CTRL_OUT)
            |=> (sample_tick == $past(osc_rise));
    endproperty
    a_mode4_int: assert property (p_mode4_int) else $error("mode four timing wrong"); // R11

    property p_mode0_int;
        @(posedge core_clk) disable iff (rst)
        (clk_en && pin_function_select == spms_pkg::MODE_STANDALONE)
            |=> (sample_tick == $past(osc_rise) && exposure_tick == sample_tick);
    endproperty
    a_mode0_int: assert property (p_mode0_int) else $error("mode zero timing wrong"); // R4

    property p_mode1_pins;
        @(posedge core_clk) disable iff (rst)
        (clk_en && pin_function_select == spms_pkg::MODE_EXT_CLK)
            |=> (!second_sync_pin_oe && !second_sync_pin_disabled);
    endproperty
    a_mode1_pins: assert property (p_mode1_pins) else $error("pin two not an input"); // R5

    property p_mode3_pins;
        @(posedge core_clk) disable iff (rst)
        (clk_en && pin_function_select == spms_pkg::MODE_TRIG_EXT_CLK)
            |=> (!first_sync_pin_oe && !second_sync_pin_oe && !sample_tick);
    endproperty
    a_mode3_pins: assert property (p_mode3_pins) else $error("mode three pin driven"); // R6

    // A held trigger level must not start a second sample
    property p_trig_once;
        @(posedge core_clk) disable iff (rst)
        (clk_en && sample_start && pin_function_select == spms_pkg::MODE_TRIG_INT &&
            $past(pin_function_select) == spms_pkg::MODE_TRIG_INT) |=> !sample_start;
    endproperty
    a_trig_once: assert property (p_trig_once) else $error("trigger started twice"); // R12

    property p_undef_mode;
        @(posedge core_clk) disable iff (rst)
        (clk_en && pin_function_select > spms_pkg::MODE_CTRL_OUT)
            |=> (!first_sync_pin_oe && !second_sync_pin_oe && second_sync_pin_disabled);
    endproperty
    a_undef_mode: assert property (p_undef_mode) else $error("undefined mode drives pin"); // R1

    // Clock enable low holds pin one, both pin enables, the pin-two disable flag and the sample tick
    property p_freeze;
        @(posedge core_clk) disable iff (rst)
        (!clk_en) |=> ($stable(first_sync_pin_oe) && $stable(first_sync_pin_out) &&
            $stable(second_sync_pin_oe) && $stable(sample_tick) &&
            $stable(second_sync_pin_disabled));
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while frozen"); // R1

    c_trig: cover property (@(posedge core_clk) disable iff (rst) sample_start && !first_sync_pin_oe);
    c_ctrl: cover property (@(posedge core_clk) disable iff (rst) first_sync_pin_oe && first_sync_pin_out);
    c_mux: cover property (@(posedge core_clk) disable iff (rst) second_sync_pin_oe && !second_sync_pin_out);
    c_ext: cover property (@(posedge core_clk) disable iff (rst) exposure_tick && !sample_tick);
    c_freeze: cover property (@(posedge core_clk) disable iff (rst) !clk_en ##1 clk_en);
endmodule

// File: shared/spms_pkg.sv
package spms_pkg;
    localparam int MODE_W = 4;
    localparam int SLOT_W = 4;

    // Pin function select field encodings
    localparam logic [3:0] MODE_STANDALONE = 4'h0;
    localparam logic [3:0] MODE_EXT_CLK = 4'h1;
    localparam logic [3:0] MODE_TRIG_INT = 4'h2;
    localparam logic [3:0] MODE_TRIG_EXT_CLK = 4'h3;
    localparam logic [3:0] MODE_CTRL_OUT = 4'h4;

    // Exposure slot codes for the extended slot states A, B, C
    localparam logic [3:0] SLOT_A = 4'ha;
    localparam logic [3:0] SLOT_B = 4'hb;
    localparam logic [3:0] SLOT_C = 4'hc;

    // Internal oscillator and core clock rates
    localparam int INT_OSC_HZ = 32768;
    localparam int CORE_HZ = 125000000;
    localparam int OSC_DIV = CORE_HZ / INT_OSC_HZ / 2;
    localparam int OSC_DIV_W = 12;

    // Start-of-sample output pulse length in core cycles
    localparam int SOS_PULSE_TICKS = 1;

    typedef enum logic [2:0] {
        SPMS_TS_INT = 3'h1,
        SPMS_TS_EXT = 3'h2,
        SPMS_TS_NONE = 3'h4
    } spms_tsrc_e;
endpackage

// File: logic/spms_sync2.sv
`timescale 1ns/10ps
module spms_sync2 #(
    parameter int W = 1
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] q_reg;
    logic [W-1:0] q_next;

    always_comb begin
        meta_next = clk_en ? d : meta_reg;
        q_next = clk_en ? meta_reg : q_reg;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            // Pins idle high on their pull-ups; avoids a false edge out of reset
            meta_reg <= '1;
            q_reg <= '1;
        end else begin
            meta_reg <= meta_next;
            q_reg <= q_next;
        end
    end

    assign q = q_reg;
endmodule

// File: dv/spms_far_model.sv
`timescale 1ns/10ps
module spms_far_model (
    input wire logic ext_drive,
    input wire logic ext_run,
    input wire logic trig_drive,
    input wire logic trig_level,
    input wire logic dev1_out,
    input wire logic dev1_oe,
    input wire logic dev2_out,
    input wire logic dev2_oe,
    output logic pin1,
    output logic pin2,
    output int rise_cnt
);
    logic ext_clk;
    // Free phase against core_clk; clock stands low when not running
    initial begin
        ext_clk = 1'b0;
        rise_cnt = 0;
        #37;
        forever begin
            #80;
            if (ext_run) begin
                ext_clk = ~ext_clk;
                if (ext_clk) rise_cnt++;
            end else begin
                ext_clk = 1'b0;
            end
        end
    end
    // Both lines pulled up when nobody drives
    assign pin1 = dev1_oe ? dev1_out : (trig_drive ? trig_level : 1'b1);
    assign pin2 = dev2_oe ? dev2_out : (ext_drive ? ext_clk : 1'b1);
endmodule

// File: dv/tb_sync_pin_mode_select.sv
`timescale 1ns/10ps
module tb_sync_pin_mode_select;
    logic core_clk, rst, clk_en, slot_abc_enabled, exposure_active, sample_start_int;
    logic [spms_pkg::MODE_W-1:0] pin_function_select;
    logic [spms_pkg::SLOT_W-1:0] sequence_slot_select;
    logic p1o, p1e, p2o, p2e, s_tick, e_tick, s_start, p2dis, pin1, pin2;
    logic ext_drive, ext_run, trig_drive, trig_level;
    int rise_cnt, st, et, ss, r0, n;
    int miscompares = 0;
    int compares = 0;
    logic [3:0] codes [4] = '{spms_pkg::SLOT_A, spms_pkg::SLOT_B, spms_pkg::SLOT_C, 4'h1};

    spms_pin_mode #(.OSC_DIV_P(4)) dut_u (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
        .pin_function_select(pin_function_select), .slot_abc_enabled(slot_abc_enabled),
        .exposure_active(exposure_active), .sequence_slot_select(sequence_slot_select),
        .sample_start_int(sample_start_int), .first_sync_pin_in(pin1),
        .second_sync_pin_in(pin2), .first_sync_pin_out(p1o), .first_sync_pin_oe(p1e),
        .second_sync_pin_out(p2o), .second_sync_pin_oe(p2e), .sample_tick(s_tick),
        .exposure_tick(e_tick), .sample_start(s_start), .second_sync_pin_disabled(p2dis));
    spms_far_model far_u (.ext_drive(ext_drive), .ext_run(ext_run), .trig_drive(trig_drive),
        .trig_level(trig_level), .dev1_out(p1o), .dev1_oe(p1e), .dev2_out(p2o),
        .dev2_oe(p2e), .pin1(pin1), .pin2(pin2), .rise_cnt(rise_cnt));

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task step(int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask
    task check(string what, logic [15:0] seen, logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task count(int k);
        st = 0;
        et = 0;
        ss = 0;
        repeat (k) begin
            step(1);
            if (s_tick === 1'b1) st++;
            if (e_tick === 1'b1) et++;
            if (s_start === 1'b1) ss++;
        end
    endtask
    task set_mode(logic [3:0] m);
        pin_function_select = m;
        step(6);
    endtask
    // Mux pin: low on emitters four to six, high otherwise, released without slots A-C
    task mux_seq(bit two);
        slot_abc_enabled = 1'b1;
        exposure_active = 1'b1;
        for (int i = 0; i < 4; i++) begin
            sequence_slot_select = codes[i];
            step(2);
            check("mux_oe", two ? p2e : p1e, 1);
            check("mux_out", two ? p2o : p1o, i == 3);
        end
        exposure_active = 1'b0;
        step(2);
        check("mux_idle", two ? p2o : p1o, 1);
        slot_abc_enabled = 1'b0;
        step(2);
        check("mux_off", two ? p2e : p1e, 0);
        check("mux_pullup", two ? pin2 : pin1, 1);
    endtask
    task run_ext(int k);
        int s0;
        int e0;
        int q0;
        r0 = rise_cnt;
        ext_run = 1'b1;
        count(k);
        s0 = st;
        e0 = et;
        q0 = ss;
        ext_run = 1'b0;
        count(10);
        st += s0;
        et += e0;
        ss += q0;
    endtask
    task trig_edge();
        trig_level = 1'b1;
        n = 0;
        while (s_start !== 1'b1 && n < 8) begin
            step(1);
            n++;
        end
        check("trig_lat", n, 3);
        step(1);
        check("trig_pulse", s_start, 0);
        trig_level = 1'b0;
        step(6);
    endtask

    task t_mode0();
        set_mode(spms_pkg::MODE_STANDALONE);
        mux_seq(0);
        check("m0_p2dis", p2dis, 1);
        check("m0_p2oe", p2e, 0);
        count(80);
        check("m0_stick", st, 10);
        check("m0_etick", et, 10);
    endtask
    task t_mode1();
        ext_drive = 1'b1;
        set_mode(spms_pkg::MODE_EXT_CLK);
        check("m1_p2oe", p2e, 0);
        mux_seq(0);
        count(80);
        check("m1_still", st, 0);
        run_ext(400);
        check("m1_stick", st, rise_cnt - r0);
        check("m1_etick", et, rise_cnt - r0);
    endtask
    task t_mode2();
        ext_drive = 1'b0;
        trig_drive = 1'b1;
        set_mode(spms_pkg::MODE_TRIG_INT);
        check("m2_p1oe", p1e, 0);
        trig_edge();
        trig_edge();
        mux_seq(1);
        count(80);
        check("m2_stick", st, 0);
        check("m2_etick", et, 10);
    endtask
    task t_mode3();
        ext_drive = 1'b1;
        set_mode(spms_pkg::MODE_TRIG_EXT_CLK);
        trig_edge();
        run_ext(400);
        check("m3_etick", et, rise_cnt - r0);
        check("m3_start", ss, 0);
    endtask
    task t_mode4();
        trig_drive = 1'b0;
        ext_drive = 1'b0;
        set_mode(spms_pkg::MODE_CTRL_OUT);
        check("m4_p1oe", p1e, 1);
        sample_start_int = 1'b1;
        step(1);
        sample_start_int = 1'b0;
        check("m4_sos", p1o, 1);
        step(1);
        check("m4_sos_end", p1o, 0);
        mux_seq(1);
        // A running clock on pin two must not move the internal timing
        ext_drive = 1'b1;
        ext_run = 1'b1;
        count(80);
        ext_run = 1'b0;
        check("m4_stick", st, 10);
        check("m4_etick", et, 10);
        ext_drive = 1'b0;
        set_mode(4'h5);
        check("undef_oe", {p1e, p2e, p2dis}, 3'h1);
        clk_en = 1'b0;
        set_mode(spms_pkg::MODE_TRIG_INT);
        check("frz_p2dis", p2dis, 1);
        clk_en = 1'b1;
        step(2);
        check("run_p2dis", p2dis, 0);
    endtask

    task tally_and_finish();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        #100000;
        miscompares++;
        tally_and_finish();
    end
    initial begin
        rst = 1'b1;
        clk_en = 1'b1;
        pin_function_select = spms_pkg::MODE_STANDALONE;
        {slot_abc_enabled, exposure_active, sample_start_int} = 3'h0;
        sequence_slot_select = 4'h0;
        {ext_drive, ext_run, trig_drive, trig_level} = 4'h0;
        step(20);
        rst = 1'b0;
        step(2);
        t_mode0();
        t_mode1();
        t_mode2();
        t_mode3();
        t_mode4();
        tally_and_finish();
    end
endmodule
